// ==== shared/iuvf_consts.svh ====
// Functional notes
// - 16-bit linear undervoltage threshold compared against input
// - Response 00 keeps running, no interruption
// - Response 01 runs for delay, then applies retry setting if fault remains
// - Response 10 disables output, then retry setting
// - Response 11 latches output off until cleared
// - Status bit clear or clear-faults unlatches
// - Output off-then-on cycle also unlatches
// - Retry count 000 means no restart
// - Counts 1-6 retry that often, then latch
// - Attempt starts spaced by delay times unit
// - Count 111 retries until off or shutdown
// - Delay field decodes to two power field units
// - Delay serves ride-through or retry spacing
// - Unit length comes from time-unit register
`ifndef IUVF_CONSTS_SVH
`define IUVF_CONSTS_SVH
// Command codes
`define IUVF_CMD_OPERATION 8'h01
`define IUVF_CMD_CLEAR_FAULTS 8'h03
`define IUVF_CMD_THRESHOLD 8'h59
`define IUVF_CMD_ACTION 8'h5a
`define IUVF_CMD_STATUS_INPUT 8'h7c
`define IUVF_CMD_TIME_UNIT 8'hd2
// Field positions
`define IUVF_OP_ON_BIT 7
`define IUVF_STAT_UV_BIT 4
`define IUVF_RESP_HI 7
`define IUVF_RESP_LO 6
`define IUVF_RETRY_HI 5
`define IUVF_RETRY_LO 3
`define IUVF_DELAY_HI 2
`define IUVF_DELAY_LO 0
`define IUVF_LIN_EXP_HI 15
`define IUVF_LIN_EXP_LO 11
`define IUVF_LIN_MANT_HI 10
// Reset values
`define IUVF_RST_THRESHOLD 16'h0000
`define IUVF_RST_ACTION 8'hc0
`define IUVF_RST_TIME_UNIT 16'h0001
`define IUVF_RST_OPERATION 8'h80
// Retry encodings
`define IUVF_RETRY_NONE 3'h0
`define IUVF_RETRY_FOREVER 3'h7
// Timing: time unit register counts microseconds
`define IUVF_CLK_PERIOD_NS 10
`define IUVF_UNIT_NS 1000
`define IUVF_CYC_PER_US (`IUVF_UNIT_NS / `IUVF_CLK_PERIOD_NS)
`endif

// ==== shared/iuvf_pkg.sv ====
package iuvf_pkg;
  // Fault response field
  typedef enum logic [1:0] {
    IUVF_RESP_IGNORE = 2'b00,
    IUVF_RESP_RIDE = 2'b01,
    IUVF_RESP_RETRY = 2'b10,
    IUVF_RESP_LATCH = 2'b11
  } iuvf_resp_t;
  // Output sequencing states
  typedef enum logic [2:0] {
    IUVF_OFF = 3'b000,
    IUVF_RUN = 3'b001,
    IUVF_RIDE = 3'b010,
    IUVF_WAIT = 3'b011,
    IUVF_TRY = 3'b100,
    IUVF_LATCHED = 3'b101
  } iuvf_state_t;
endpackage : iuvf_pkg

// ==== shared/iuvf_tmr_if.sv ====
`timescale 1ns/1ps
interface iuvf_tmr_if;
  logic start;
  logic [7:0] units;
  logic [15:0] unit_us;
  logic done;
  logic busy;
  modport ctrl (output start, output units, output unit_us, input done, input busy);
  modport tmr (input start, input units, input unit_us, output done, output busy);
endinterface : iuvf_tmr_if

// ==== rtl/iuvf_delay_timer.sv ====
`timescale 1ns/1ps
`include "iuvf_consts.svh"
module iuvf_delay_timer
  import iuvf_pkg::*;
#(
  parameter int CYC_PER_US = `IUVF_CYC_PER_US
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Timer control
  iuvf_tmr_if.tmr t
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] pre;
    logic [15:0] us;
    logic [7:0] left;
    logic [15:0] unit_us;
  } iuvf_tmr_st_t;

  iuvf_tmr_st_t st_ff;
  iuvf_tmr_st_t nxt_st;
  localparam logic [15:0] PRE_LAST = 16'(CYC_PER_US - 1);

  // Count microsecond ticks, then units, restart on every start
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (t.start)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.pre = 16'h0000;
      nxt_st.us = 16'h0000;
      nxt_st.left = t.units;
      nxt_st.unit_us = (t.unit_us == 16'h0000) ? 16'h0001 : t.unit_us;
    end
    else if (st_ff.busy)
    begin
      nxt_st.pre = st_ff.pre + 16'h0001;
      if (st_ff.pre == PRE_LAST)
      begin
        nxt_st.pre = 16'h0000;
        nxt_st.us = st_ff.us + 16'h0001;
        if (st_ff.us == st_ff.unit_us - 16'h0001)
        begin
          nxt_st.us = 16'h0000;
          nxt_st.left = st_ff.left - 8'h01;
          if (st_ff.left == 8'h01)
          begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign t.done = st_ff.done;
  assign t.busy = st_ff.busy;

  AST_TMR_START: assert property (@(posedge ref_clk) disable iff (srst)
    t.start |=> t.busy && !t.done) else $error("Timer did not start");
endmodule : iuvf_delay_timer

// ==== rtl/iuvf_top.sv ====
`timescale 1ns/1ps
`include "iuvf_consts.svh"
module iuvf_top
  import iuvf_pkg::*;
#(
  parameter int CYC_PER_US = `IUVF_CYC_PER_US
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  // Converter side
  input wire logic [15:0] vin_meas,
  input wire logic ctrl_pin,
  input wire logic other_fault_off,
  output logic out_enable,
  output logic uv_fault,
  output logic [2:0] retry_used
);
  typedef struct packed {
    logic [15:0] thr;
    logic [7:0] action;
    logic [15:0] unit_us;
    logic op_on;
    logic ctrl_s1;
    logic ctrl_s2;
    logic en_prev;
    logic fault_flag;
    logic out_en;
    logic [2:0] attempts;
    iuvf_state_t state;
    logic [15:0] rdata;
  } iuvf_st_t;

  iuvf_st_t st_ff;
  iuvf_st_t nxt_st;
  iuvf_tmr_if tmr_bus ();

  // Linear value to fixed point, 16 fraction bits, negatives as zero
  function automatic logic [47:0] iuvf_lin_fix(input logic [15:0] v);
    logic [4:0] e;
    logic [47:0] m;
    e = v[`IUVF_LIN_EXP_HI:`IUVF_LIN_EXP_LO];
    m = v[`IUVF_LIN_MANT_HI] ? 48'h0 : {21'h0, v[`IUVF_LIN_MANT_HI:0], 16'h0};
    if (e[4])
      iuvf_lin_fix = m >> (~e + 5'h01);
    else
      iuvf_lin_fix = m << e;
  endfunction : iuvf_lin_fix

  logic en;
  logic en_rise;
  logic fault_now;
  logic clr_bit;
  logic clr_cf;
  logic clr_any;
  logic [1:0] resp;
  logic [2:0] retries;
  logic [2:0] dly;
  logic [7:0] units;
  logic tmr_start;

  // Decoded fields and commanded enable
  assign resp = st_ff.action[`IUVF_RESP_HI:`IUVF_RESP_LO];
  assign retries = st_ff.action[`IUVF_RETRY_HI:`IUVF_RETRY_LO];
  assign dly = st_ff.action[`IUVF_DELAY_HI:`IUVF_DELAY_LO];
  assign units = 8'h01 << dly;
  assign en = st_ff.ctrl_s2 && st_ff.op_on;
  assign en_rise = en && !st_ff.en_prev;
  assign fault_now = st_ff.out_en &&
    (iuvf_lin_fix(vin_meas) < iuvf_lin_fix(st_ff.thr));
  assign clr_bit = cmd_wr && (cmd_code == `IUVF_CMD_STATUS_INPUT) &&
    cmd_wdata[`IUVF_STAT_UV_BIT];
  assign clr_cf = cmd_wr && (cmd_code == `IUVF_CMD_CLEAR_FAULTS);
  assign clr_any = clr_bit || clr_cf || en_rise;

  // Registers, fault flag and response sequencing
  always_comb
  begin
    nxt_st = st_ff;
    tmr_start = 1'b0;
    nxt_st.ctrl_s1 = ctrl_pin;
    nxt_st.ctrl_s2 = st_ff.ctrl_s1;
    nxt_st.en_prev = en;
    if (cmd_wr)
    begin
      unique case (cmd_code)
        `IUVF_CMD_THRESHOLD: nxt_st.thr = cmd_wdata;
        `IUVF_CMD_ACTION: nxt_st.action = cmd_wdata[7:0];
        `IUVF_CMD_TIME_UNIT: nxt_st.unit_us = cmd_wdata;
        `IUVF_CMD_OPERATION: nxt_st.op_on = cmd_wdata[`IUVF_OP_ON_BIT];
        default: ;
      endcase
    end
    if (cmd_rd)
    begin
      unique case (cmd_code)
        `IUVF_CMD_THRESHOLD: nxt_st.rdata = st_ff.thr;
        `IUVF_CMD_ACTION: nxt_st.rdata = {8'h00, st_ff.action};
        `IUVF_CMD_TIME_UNIT: nxt_st.rdata = st_ff.unit_us;
        `IUVF_CMD_OPERATION: nxt_st.rdata = {8'h00, st_ff.op_on, 7'h00};
        `IUVF_CMD_STATUS_INPUT: nxt_st.rdata = 16'(st_ff.fault_flag) << `IUVF_STAT_UV_BIT;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
    // Sticky flag, a new fault wins over a clear
    if (clr_any)
      nxt_st.fault_flag = 1'b0;
    if (fault_now)
      nxt_st.fault_flag = 1'b1;
    unique case (st_ff.state)
      IUVF_OFF:
      begin
        nxt_st.out_en = 1'b0;
        nxt_st.attempts = 3'h0;
        if (en && !other_fault_off)
        begin
          nxt_st.state = IUVF_RUN;
          nxt_st.out_en = 1'b1;
        end
      end
      IUVF_RUN:
      begin
        if (fault_now)
        begin
          unique case (resp)
            IUVF_RESP_IGNORE: ;
            IUVF_RESP_RIDE:
            begin
              nxt_st.state = IUVF_RIDE;
              tmr_start = 1'b1;
            end
            IUVF_RESP_RETRY: nxt_st.state = IUVF_WAIT;
            IUVF_RESP_LATCH: nxt_st.state = IUVF_LATCHED;
          endcase
        end
      end
      IUVF_RIDE:
      begin
        if (tmr_bus.done)
          nxt_st.state = fault_now ? IUVF_WAIT : IUVF_RUN;
      end
      IUVF_WAIT:
      begin
        nxt_st.out_en = 1'b0;
        if (tmr_bus.done)
        begin
          nxt_st.state = IUVF_TRY;
          nxt_st.out_en = 1'b1;
          tmr_start = 1'b1;
        end
      end
      IUVF_TRY:
      begin
        if (fault_now)
          nxt_st.state = IUVF_WAIT;
        else if (tmr_bus.done)
        begin
          nxt_st.state = IUVF_RUN;
          nxt_st.attempts = 3'h0;
        end
      end
      IUVF_LATCHED:
      begin
        nxt_st.out_en = 1'b0;
        if (clr_any)
        begin
          nxt_st.state = IUVF_OFF;
          nxt_st.attempts = 3'h0;
        end
      end
      default:
      begin
        nxt_st.state = IUVF_OFF;
        nxt_st.out_en = 1'b0;
      end
    endcase
    // A new wait decides between another attempt and latching off
    if (nxt_st.state == IUVF_WAIT && st_ff.state != IUVF_WAIT)
    begin
      nxt_st.out_en = 1'b0;
      if (retries == `IUVF_RETRY_NONE)
        nxt_st.state = IUVF_LATCHED;
      else if (retries != `IUVF_RETRY_FOREVER && st_ff.attempts >= retries)
        nxt_st.state = IUVF_LATCHED;
      else
      begin
        tmr_start = 1'b1;
        if (retries != `IUVF_RETRY_FOREVER)
          nxt_st.attempts = st_ff.attempts + 3'h1;
      end
    end
    if (nxt_st.state == IUVF_LATCHED)
      nxt_st.out_en = 1'b0;
    // Commanded off or another shutdown ends any sequence
    if (st_ff.state != IUVF_OFF && st_ff.state != IUVF_LATCHED &&
        (!en || other_fault_off))
    begin
      nxt_st.state = IUVF_OFF;
      nxt_st.out_en = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_ff <= '0;
      st_ff.thr <= `IUVF_RST_THRESHOLD;
      st_ff.action <= `IUVF_RST_ACTION;
      st_ff.unit_us <= `IUVF_RST_TIME_UNIT;
      st_ff.op_on <= 1'(`IUVF_RST_OPERATION >> `IUVF_OP_ON_BIT);
      st_ff.state <= IUVF_OFF;
    end
    else
      st_ff <= nxt_st;
  end

  // Delay timer
  assign tmr_bus.start = tmr_start;
  assign tmr_bus.units = units;
  assign tmr_bus.unit_us = st_ff.unit_us;

  iuvf_delay_timer #(.CYC_PER_US(CYC_PER_US)) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .t(tmr_bus.tmr)
  );

  // Outputs
  assign cmd_rdata = st_ff.rdata;
  assign out_enable = st_ff.out_en;
  assign uv_fault = st_ff.fault_flag;
  assign retry_used = st_ff.attempts;

  AST_IGNORE: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_RUN && fault_now && resp == 2'b00 && en && !other_fault_off
    |=> st_ff.state == IUVF_RUN && st_ff.out_en) else $error("Ignored fault stopped output");
  AST_RIDE: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_RUN && fault_now && resp == 2'b01 && en && !other_fault_off
    |=> st_ff.state == IUVF_RIDE && st_ff.out_en) else $error("Ride-through not entered");
  AST_DISABLE: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_RUN && fault_now && resp == 2'b10 |=> !st_ff.out_en)
    else $error("Output not disabled on fault");
  AST_LATCH: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_RUN && fault_now && resp == 2'b11 && en && !other_fault_off
    |=> st_ff.state == IUVF_LATCHED && !st_ff.out_en) else $error("Fault did not latch off");
  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_LATCHED && clr_cf |=> st_ff.state == IUVF_OFF && st_ff.attempts == 3'h0)
    else $error("Clear-faults did not unlatch");
  AST_NO_RETRY: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_RUN && fault_now && resp == 2'b10 && retries == 3'h0 && en &&
    !other_fault_off |=> st_ff.state == IUVF_LATCHED) else $error("Retried with count zero");
  AST_UNITS: assert property (@(posedge ref_clk) disable iff (srst)
    tmr_start |-> $onehot(tmr_bus.units) && tmr_bus.units[dly])
    else $error("Bad delay decode");
  AST_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
    fault_now |=> st_ff.fault_flag) else $error("Fault flag not set");
  AST_LIMIT: assert property (@(posedge ref_clk) disable iff (srst)
    retries != 3'h7 && retries != 3'h0 |-> st_ff.attempts <= retries ||
    $changed(st_ff.action)) else $error("Attempts exceed retry count");
  AST_OFF_LATCHED: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.state == IUVF_LATCHED && $past(st_ff.state) == IUVF_LATCHED |-> !st_ff.out_en)
    else $error("Output on while latched");
endmodule : iuvf_top

// ==== sim/iuvf_stage_model.sv ====
`timescale 1ns/1ps
module iuvf_stage_model
(
  // Clock
  ref_clk,
  // Input rail as set by the bench
  vin_src,
  // Measured input voltage
  vin_meas
);
  input wire logic ref_clk;
  input wire logic [15:0] vin_src;
  output logic [15:0] vin_meas;
  // Sampling by the converter front end costs one cycle
  always_ff @(posedge ref_clk)
  begin
    vin_meas <= vin_src;
  end
endmodule : iuvf_stage_model

// ==== sim/test_input_undervoltage_fault_handler.sv ====
`timescale 1ns/1ps
module test_input_undervoltage_fault_handler;
  // Bench signals
  logic ref_clk, srst, cmd_wr, cmd_rd, ctrl_pin, other_fault_off, out_enable, uv_fault;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, vin_src, vin_meas;
  logic [2:0] retry_used;
  int bad_count = 0;
  int n_tests = 0;
  int n;
  localparam logic [15:0] VOK = 16'h0030;
  localparam logic [15:0] VLO = 16'h0020;
  localparam logic [15:0] THR = 16'h0028;

  // One clock cycle per microsecond keeps the delays short
  iuvf_top #(.CYC_PER_US(1)) u_iuvf_top
  (
    .ref_clk(ref_clk), .srst(srst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .vin_meas(vin_meas), .ctrl_pin(ctrl_pin), .other_fault_off(other_fault_off),
    .out_enable(out_enable), .uv_fault(uv_fault), .retry_used(retry_used)
  );
  iuvf_stage_model u_iuvf_stage_model
  (
    .ref_clk(ref_clk), .vin_src(vin_src), .vin_meas(vin_meas)
  );

  // Clock generator
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One command write, strobe held for a single edge
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge ref_clk);
    cmd_wr = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge ref_clk);
    cmd_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr

  // One command read, data checked once it has landed
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    @(negedge ref_clk);
    cmd_rd = 1'b1;
    cmd_code = code;
    @(negedge ref_clk);
    cmd_rd = 1'b0;
    @(negedge ref_clk);
    chk(cmd_rdata, exp);
  endtask : rd

  // Bounded wait for the output enable level
  task automatic wait_en(input logic val, input int lim, output int cnt);
    cnt = 0;
    while (out_enable !== val && cnt < lim)
    begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask : wait_en

  // Output enable must keep one level for a span
  task automatic hold(input logic val, input int cyc);
    repeat (cyc)
    begin
      @(negedge ref_clk);
      chk(out_enable, val);
    end
  endtask : hold

  // Power cycle through the pin plus a fault clear
  task automatic recover;
    vin_src = VOK;
    other_fault_off = 1'b0;
    ctrl_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    ctrl_pin = 1'b1;
    wr(8'h03, 16'h0000);
    wait_en(1'b1, 20, n);
    chk(out_enable, 1'b1);
    chk(uv_fault, 1'b0);
    chk(retry_used, 3'h0);
  endtask : recover

  // Disable-and-retry with a given unit, delay field and retry count
  task automatic retry_case(input int unit, input int fld, input int tries);
    int d;
    d = (unit == 0 ? 1 : unit) << fld;
    wr(8'hd2, unit[15:0]);
    wr(8'h5a, {8'h00, 2'b10, tries[2:0], fld[2:0]});
    vin_src = VLO;
    wait_en(1'b0, 4, n);
    chk(out_enable, 1'b0);
    repeat (tries)
    begin
      wait_en(1'b1, d + 4, n);
      chk(16'(n + 1 >= d && n <= d + 3), 16'h0001);
      wait_en(1'b0, 4, n);
    end
    hold(1'b0, 2 * d + 8);
    chk(retry_used, tries[2:0]);
    recover();
  endtask : retry_case

  // Endless retries stopped by the pin or by another fault
  task automatic forever_case(input bit by_pin);
    wr(8'hd2, 16'h0001);
    wr(8'h5a, 16'h00b9);
    vin_src = VLO;
    repeat (8)
    begin
      wait_en(1'b0, 6, n);
      wait_en(1'b1, 8, n);
      chk(out_enable, 1'b1);
    end
    if (by_pin)
      ctrl_pin = 1'b0;
    else
      other_fault_off = 1'b1;
    wait_en(1'b0, 8, n);
    hold(1'b0, 40);
    recover();
  endtask : forever_case

  // Verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected run length
  initial
  begin
    #300000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  // Test sequence
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    vin_src = VOK;
    ctrl_pin = 1'b1;
    other_fault_off = 1'b0;
    srst = 1'b1;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    rd(8'h59, 16'h0000);
    rd(8'h5a, 16'h00c0);
    rd(8'hd2, 16'h0001);
    rd(8'h01, 16'h0080);
    rd(8'h00, 16'h0000);
    wr(8'h59, THR);
    rd(8'h59, THR);
    wait_en(1'b1, 20, n);
    chk(out_enable, 1'b1);
    // Ignore response keeps running but flags the fault
    wr(8'h5a, 16'h0000);
    vin_src = VLO;
    hold(1'b1, 20);
    chk(uv_fault, 1'b1);
    rd(8'h7c, 16'h0010);
    vin_src = VOK;
    wr(8'h03, 16'h0000);
    chk(uv_fault, 1'b0);
    rd(8'h7c, 16'h0000);
    // Latch-off response cleared four ways
    wr(8'h5a, 16'h00c0);
    for (int k = 0; k < 4; k++)
    begin
      vin_src = VLO;
      wait_en(1'b0, 4, n);
      vin_src = VOK;
      hold(1'b0, 30);
      chk(uv_fault, 1'b1);
      if (k == 0)
        wr(8'h7c, 16'h0010);
      else if (k == 1)
        wr(8'h03, 16'h0000);
      else if (k == 2)
        wr(8'h01, 16'h0000);
      else
        ctrl_pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      ctrl_pin = 1'b1;
      if (k == 2)
        wr(8'h01, 16'h0080);
      wait_en(1'b1, 20, n);
      @(negedge ref_clk);
      chk(out_enable, 1'b1);
      chk(uv_fault, 1'b0);
    end
    // No detection while the output is off
    wr(8'h01, 16'h0000);
    wr(8'h03, 16'h0000);
    vin_src = VLO;
    hold(1'b0, 10);
    chk(uv_fault, 1'b0);
    // Turn back on before the power cycle, recover expects a running output
    vin_src = VOK;
    wr(8'h01, 16'h0080);
    recover();
    // Ride-through for eight units, then no retry
    wr(8'h5a, 16'h0043);
    vin_src = VLO;
    hold(1'b1, 8);
    wait_en(1'b0, 8, n);
    chk(16'(n <= 4), 16'h0001);
    hold(1'b0, 20);
    recover();
    // Retry counts, delay decode and unit scaling
    retry_case(1, 1, 0);
    retry_case(1, 0, 1);
    retry_case(3, 2, 2);
    retry_case(1, 7, 1);
    retry_case(0, 1, 6);
    // Successful restart clears the attempt count
    wr(8'h5a, 16'h0092);
    vin_src = VLO;
    wait_en(1'b0, 4, n);
    vin_src = VOK;
    wait_en(1'b1, 12, n);
    hold(1'b1, 12);
    chk(retry_used, 3'h0);
    forever_case(1'b1);
    forever_case(1'b0);
    report_and_stop();
  end
endmodule : test_input_undervoltage_fault_handler
